// >>> dv/ddtc_timer_props.sv
`default_nettype none
// ==========================================================
// bus answer and interrupt relations at the channel's ports
module ddtc_timer_props
  import ddtc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic count_clock,
  input wire logic timer_irq_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic req;
  logic rd;
  // request taken, and read answer showing
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = wb_ack_o && !wb_we_i;
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_no_idle_ack; !wb_stb_i |=> !wb_ack_o; endproperty
  a_no_idle_ack: assert property (p_no_idle_ack) else $error("stray ack");
  property p_wr_dat; wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0; endproperty
  a_wr_dat: assert property (p_wr_dat) else $error("write data out");
  property p_masked; rd && wb_adr_i == DDTC_ADDR_MASKED_STATUS
    |-> wb_dat_o == {31'h0, $past(timer_irq_out)}; endproperty
  a_masked: assert property (p_masked) else $error("masked read");
  property p_raw; rd && wb_adr_i == DDTC_ADDR_RAW_STATUS
    |-> wb_dat_o[31:1] == 31'h0 && (wb_dat_o[0] || !$past(timer_irq_out));
  endproperty
  a_raw: assert property (p_raw) else $error("raw read");
  property p_clear; $stable(count_clock)[*4] ##0
    (req && wb_we_i && wb_adr_i == DDTC_ADDR_IRQ_CLEAR) |=> !timer_irq_out;
  endproperty
  a_clear: assert property (p_clear) else $error("irq not cleared");
  property p_sticky; timer_irq_out && !(req && wb_we_i) |=> timer_irq_out;
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped");
endmodule
bind ddtc_timer ddtc_timer_props u_props (.clk(clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .count_clock(count_clock), .timer_irq_out(timer_irq_out));
`default_nettype wire

// >>> dv/test_ddtc_timer.sv
`default_nettype none
// ==========================================================
// self-checking bench for one timer channel
module test_ddtc_timer;
  import ddtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic timer_irq_out;
  logic count_clock = 1'b0;
  logic count_clock_qualifier = 1'b1;
  logic [31:0] expq[$];
  logic [31:0] r;
  int n_errors = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  ddtc_timer DUT (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .count_clock(count_clock),
    .count_clock_qualifier(count_clock_qualifier),
    .timer_irq_out(timer_irq_out));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 64);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 64) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic irq(input logic e);
    check({31'h0, timer_irq_out}, {31'h0, e});
  endtask
  // timer clock pulses, each level held several cycles
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) count_clock <= 1'b1;
      repeat (3) @(posedge clk);
      count_clock <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  // read answers against the oldest note
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
      check(wb_dat_o, expq.pop_front());
    end
  end
  initial begin
    void'($urandom(50));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(DDTC_ADDR_CONTROL, 32'h20);
    rd(DDTC_ADDR_BG_RELOAD, 32'h0);
    rd(DDTC_ADDR_RAW_STATUS, 32'h0);
    rd(8'h1c, 32'h0);
    // free run in 16 bits, sticky flag, clear
    wr(DDTC_ADDR_PRIMARY_LOAD, 32'h3);
    wr(DDTC_ADDR_CONTROL, 32'ha0);
    tick(1);
    rd(DDTC_ADDR_CURRENT_VALUE, 32'h3);
    tick(3);
    irq(1'b1);
    tick(1);
    rd(DDTC_ADDR_CURRENT_VALUE, 32'hffff);
    rd(DDTC_ADDR_RAW_STATUS, 32'h1);
    wr(DDTC_ADDR_RAW_STATUS, 32'h0);
    rd(DDTC_ADDR_RAW_STATUS, 32'h1);
    wr(DDTC_ADDR_IRQ_CLEAR, $urandom());
    irq(1'b0);
    // zero load while stopped and masked
    wr(DDTC_ADDR_CONTROL, 32'h0);
    wr(DDTC_ADDR_PRIMARY_LOAD, 32'h0);
    tick(1);
    rd(DDTC_ADDR_RAW_STATUS, 32'h1);
    rd(DDTC_ADDR_MASKED_STATUS, 32'h0);
    irq(1'b0);
    wr(DDTC_ADDR_CONTROL, 32'h20);
    irq(1'b1);
    wr(DDTC_ADDR_IRQ_CLEAR, 32'h0);
    // periodic 32-bit with a background reload
    r = ($urandom() | 32'h10000) & 32'hffff0000;
    wr(DDTC_ADDR_PRIMARY_LOAD, 32'h2);
    tick(1);
    wr(DDTC_ADDR_CONTROL, 32'he2);
    rd(DDTC_ADDR_CONTROL, 32'he2);
    wr(DDTC_ADDR_BG_RELOAD, r);
    rd(DDTC_ADDR_CURRENT_VALUE, 32'h2);
    tick(1);
    rd(DDTC_ADDR_CURRENT_VALUE, 32'h1);
    rd(DDTC_ADDR_PRIMARY_LOAD, r);
    irq(1'b0);
    tick(1);
    irq(1'b1);
    tick(1);
    rd(DDTC_ADDR_CURRENT_VALUE, r);
    tick(1);
    rd(DDTC_ADDR_CURRENT_VALUE, r - 32'h1);
    wr(DDTC_ADDR_CONTROL, 32'h0);
    wr(DDTC_ADDR_IRQ_CLEAR, 32'h0);
    // divide by 16 and by 256
    for (int i = 1; i < 3; i++) begin
      wr(DDTC_ADDR_CONTROL, 32'h0);
      wr(DDTC_ADDR_PRIMARY_LOAD, 32'h5);
      tick(1);
      wr(DDTC_ADDR_CONTROL, 32'h80 | (32'(i) << 2));
      tick(i == 1 ? 15 : 255);
      rd(DDTC_ADDR_CURRENT_VALUE, 32'h5);
      tick(1);
      rd(DDTC_ADDR_CURRENT_VALUE, 32'h4);
    end
    // unqualified edges, then a stopped timer
    wr(DDTC_ADDR_CONTROL, 32'h0);
    wr(DDTC_ADDR_CONTROL, 32'h80);
    @(posedge clk) count_clock_qualifier <= 1'b0;
    tick(2);
    rd(DDTC_ADDR_CURRENT_VALUE, 32'h4);
    @(posedge clk) count_clock_qualifier <= 1'b1;
    tick(1);
    rd(DDTC_ADDR_CURRENT_VALUE, 32'h3);
    wr(DDTC_ADDR_CONTROL, 32'h0);
    tick(2);
    rd(DDTC_ADDR_CURRENT_VALUE, 32'h3);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire

// >>> rtl/ddtc_pkg.sv
`default_nettype none
// ==========================================================
// register map, field layout and reset values
package ddtc_pkg;
  // byte addresses of the word registers
  localparam logic [7:0] DDTC_ADDR_PRIMARY_LOAD = 8'h00;
  localparam logic [7:0] DDTC_ADDR_CURRENT_VALUE = 8'h04;
  localparam logic [7:0] DDTC_ADDR_CONTROL = 8'h08;
  localparam logic [7:0] DDTC_ADDR_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] DDTC_ADDR_RAW_STATUS = 8'h10;
  localparam logic [7:0] DDTC_ADDR_MASKED_STATUS = 8'h14;
  localparam logic [7:0] DDTC_ADDR_BG_RELOAD = 8'h18;

  // control register field positions
  localparam int DDTC_CTRL_RUN_BIT = 7;
  localparam int DDTC_CTRL_PERIODIC_BIT = 6;
  localparam int DDTC_CTRL_IRQ_EN_BIT = 5;
  localparam int DDTC_CTRL_PRE_HI = 3;
  localparam int DDTC_CTRL_PRE_LO = 2;
  localparam int DDTC_CTRL_WIDTH_BIT = 1;
  localparam int DDTC_STATUS_BIT = 0;

  // reset values
  localparam logic DDTC_RST_RUN = 1'b0;
  localparam logic DDTC_RST_PERIODIC = 1'b0;
  localparam logic DDTC_RST_IRQ_EN = 1'b1;
  localparam logic DDTC_RST_WIDTH = 1'b0;
  localparam logic [31:0] DDTC_RST_RELOAD = 32'h0000_0000;
  localparam logic [31:0] DDTC_RST_COUNT = 32'hffff_ffff;

  // counter constants
  localparam logic [31:0] DDTC_ONE = 32'h0000_0001;
  localparam logic [31:0] DDTC_ZERO = 32'h0000_0000;
  localparam logic [31:0] DDTC_LOW_HALF = 32'h0000_ffff;
  localparam logic [15:0] DDTC_ALL_ONES_16 = 16'hffff;
  localparam logic [31:0] DDTC_ALL_ONES_32 = 32'hffff_ffff;

  // prescale terminal counts
  localparam logic [7:0] DDTC_PRE_TERM_16 = 8'h0f;
  localparam logic [7:0] DDTC_PRE_TERM_256 = 8'hff;
  localparam logic [7:0] DDTC_PRE_CNT_RST = 8'h00;
  localparam logic [7:0] DDTC_PRE_CNT_STEP = 8'h01;

  typedef enum logic [1:0] {
    DDTC_PRE_DIV1 = 2'b00,
    DDTC_PRE_DIV16 = 2'b01,
    DDTC_PRE_DIV256 = 2'b10,
    DDTC_PRE_UNDEF = 2'b11
  } ddtc_pre_t;
endpackage
`default_nettype wire

// >>> rtl/ddtc_prescale.sv
`default_nettype none
// ==========================================================
// prescaler: passes 1 of 1, 16 or 256 qualified edges
module ddtc_prescale (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic edge_in,
  input wire ddtc_pkg::ddtc_pre_t sel,
  output logic tick
);
  import ddtc_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
  } ddtc_pre_state_t;

  ddtc_pre_state_t s;
  ddtc_pre_state_t next_s;
  logic at_term;

  // terminal count per divide code; undefined code acts as 256
  always_comb begin
    case (sel)
      DDTC_PRE_DIV1: at_term = 1'b1;
      DDTC_PRE_DIV16: at_term = (s.cnt[3:0] == DDTC_PRE_TERM_16[3:0]);
      DDTC_PRE_DIV256: at_term = (s.cnt == DDTC_PRE_TERM_256);
      default: at_term = (s.cnt == DDTC_PRE_TERM_256);
    endcase
    tick = edge_in && at_term && !clear;
  end

  // edge counter, restarted by clear
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.cnt = DDTC_PRE_CNT_RST;
    end else if (edge_in) begin
      if (at_term) begin
        next_s.cnt = DDTC_PRE_CNT_RST;
      end else begin
        next_s.cnt = s.cnt + DDTC_PRE_CNT_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ddtc_sync.sv
`default_nettype none
// ==========================================================
// two-flop synchroniser for a pin level
module ddtc_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);
  import ddtc_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } ddtc_sync_state_t;

  ddtc_sync_state_t s;
  ddtc_sync_state_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s.meta = pin;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.stable;
endmodule
`default_nettype wire

// >>> rtl/ddtc_timer.sv
`default_nettype none
// Overview of operation
// - periodic mode reloads from stored reload value
// - control bit 5 enables interrupt, resets on
// - prescale field divides by 1, 16, 256
// - size bit picks 16 or 32 bits
// - any write to clear register clears interrupt
// - raw status bit 0 shows unmasked interrupt
// - masked status is raw AND enable
// - interrupt output equals masked status
// - 32-bit background reload value for periodic mode
// - background write does not restart counter
// - both load registers read shared value
// - control bit 7 runs timer, resets off
// - mode bit 0 means free running
// - primary load replaces count next qualified edge
// - load of zero raises interrupt when it lands
// ==========================================================
// one decrementing timer channel with wishbone registers
module ddtc_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_clock,
  input wire logic count_clock_qualifier,
  output logic timer_irq_out
);
  import ddtc_pkg::*;

  // ========================================================
  // state
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] reload;
    logic [31:0] direct_load;
    logic load_pending;
    logic [31:0] count;
    logic timer_run_enable;
    logic periodic_select;
    logic irq_mask_enable;
    ddtc_pre_t prescale_select;
    logic counter_width_select;
    logic raw_irq;
    logic irq_line;
    logic clk_prev;
  } ddtc_state_t;

  ddtc_state_t s;
  ddtc_state_t next_s;

  // ========================================================
  // helpers

  // merge write data into a word under byte enables
  function automatic logic [31:0] ddtc_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // the part of the count that the selected width uses
  function automatic logic [31:0] ddtc_active(
    input logic [31:0] cnt,
    input logic wide
  );
    logic [31:0] res;
    res = wide ? cnt : (cnt & DDTC_LOW_HALF);
    return res;
  endfunction

  // control register image; reserved bits read zero
  function automatic logic [31:0] ddtc_ctrl_image(
    input ddtc_state_t st
  );
    logic [31:0] res;
    res = DDTC_ZERO;
    res[DDTC_CTRL_RUN_BIT] = st.timer_run_enable;
    res[DDTC_CTRL_PERIODIC_BIT] = st.periodic_select;
    res[DDTC_CTRL_IRQ_EN_BIT] = st.irq_mask_enable;
    res[DDTC_CTRL_PRE_HI:DDTC_CTRL_PRE_LO] = st.prescale_select;
    res[DDTC_CTRL_WIDTH_BIT] = st.counter_width_select;
    return res;
  endfunction

  // status word: flag in bit 0, reserved bits read zero
  function automatic logic [31:0] ddtc_status_word(
    input logic flag
  );
    logic [31:0] res;
    res = DDTC_ZERO;
    res[DDTC_STATUS_BIT] = flag;
    return res;
  endfunction

  // read word for one register address; unmapped reads zero
  function automatic logic [31:0] ddtc_read_word(
    input ddtc_state_t st,
    input logic [7:0] adr
  );
    logic [31:0] res;
    case (adr)
      DDTC_ADDR_PRIMARY_LOAD: res = st.reload;
      DDTC_ADDR_CURRENT_VALUE: res = st.count;
      DDTC_ADDR_CONTROL: res = ddtc_ctrl_image(st);
      DDTC_ADDR_RAW_STATUS: res = ddtc_status_word(st.raw_irq);
      DDTC_ADDR_MASKED_STATUS:
        res = ddtc_status_word(st.raw_irq && st.irq_mask_enable);
      DDTC_ADDR_BG_RELOAD: res = st.reload;
      default: res = DDTC_ZERO;
    endcase
    return res;
  endfunction

  // one counted tick: decrement, or wrap or reload from zero;
  // 16-bit decrement and wrap keep bits 31:16; a periodic reload loads all 32 bits
  function automatic logic [31:0] ddtc_count_step(
    input logic [31:0] cnt,
    input logic wide,
    input logic periodic,
    input logic [31:0] reload
  );
    logic [31:0] res;
    res = cnt;
    if (ddtc_active(cnt, wide) == DDTC_ZERO) begin
      if (periodic) begin
        res = reload;
      end else if (wide) begin
        res = DDTC_ALL_ONES_32;
      end else begin
        res = {cnt[31:16], DDTC_ALL_ONES_16};
      end
    end else if (wide) begin
      res = cnt - DDTC_ONE;
    end else begin
      res = {cnt[31:16], cnt[15:0] - DDTC_ONE[15:0]};
    end
    return res;
  endfunction

  // ========================================================
  // pin synchronisers
  // both pins take the same two-flop delay, so the qualifier
  // is seen in the same cycle as the edge that it qualifies
  logic clk_level;
  logic qual_level;

  ddtc_sync u_sync_clk (
    .clk(clk),
    .nrst(nrst),
    .pin(count_clock),
    .level(clk_level)
  );

  ddtc_sync u_sync_qual (
    .clk(clk),
    .nrst(nrst),
    .pin(count_clock_qualifier),
    .level(qual_level)
  );

  // qualified rising edge of the count clock
  // clk_prev resets low like the idle pin: no false edge
  logic qual_edge;
  assign qual_edge = clk_level && !s.clk_prev && qual_level;

  // ========================================================
  // prescaler
  logic pre_tick;
  logic pre_clear;

  // restart division when stopped or when a load lands
  // so a fresh count always gets a full prescaled period
  assign pre_clear = !s.timer_run_enable || (qual_edge && s.load_pending);

  ddtc_prescale u_prescale (
    .clk(clk),
    .nrst(nrst),
    .clear(pre_clear),
    .edge_in(qual_edge),
    .sel(s.prescale_select),
    .tick(pre_tick)
  );

  // ========================================================
  // bus decode
  logic bus_req;
  logic bus_wr;
  logic wr_load;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_bg;

  // one access per request, committed with the ack
  // ack gating keeps a held strobe from being taken twice
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !s.ack;
    bus_wr = bus_req && wb_we_i;
    wr_load = bus_wr && (wb_adr_i == DDTC_ADDR_PRIMARY_LOAD);
    wr_ctrl = bus_wr && (wb_adr_i == DDTC_ADDR_CONTROL);
    wr_clear = bus_wr && (wb_adr_i == DDTC_ADDR_IRQ_CLEAR);
    wr_bg = bus_wr && (wb_adr_i == DDTC_ADDR_BG_RELOAD);
  end

  // ========================================================
  // counter events
  logic [31:0] active_cnt;
  logic count_tick;
  logic load_lands;
  logic hit_zero;

  // a landing load takes the edge, so no decrement with it
  always_comb begin
    active_cnt = ddtc_active(s.count, s.counter_width_select);
    load_lands = qual_edge && s.load_pending;
    count_tick = s.timer_run_enable && pre_tick && !load_lands;
    hit_zero = count_tick && (active_cnt == DDTC_ONE);
  end

  // ========================================================
  // next state
  logic [31:0] ctrl_new;

  always_comb begin
    next_s = s;
    ctrl_new = ddtc_merge(ddtc_ctrl_image(s), wb_dat_i, wb_sel_i);

    // bus answer: ack for one cycle, every address answers
    next_s.ack = bus_req;
    // unmapped writes fall through and change nothing
    if (bus_req && !wb_we_i) begin
      next_s.rdata = ddtc_read_word(s, wb_adr_i);
    end else if (bus_req) begin
      next_s.rdata = DDTC_ZERO;
    end

    // control register; reserved bit 4 is not stored
    // mode, size and prescale are only safe to change stopped
    if (wr_ctrl) begin
      next_s.timer_run_enable = ctrl_new[DDTC_CTRL_RUN_BIT];
      next_s.periodic_select = ctrl_new[DDTC_CTRL_PERIODIC_BIT];
      next_s.irq_mask_enable = ctrl_new[DDTC_CTRL_IRQ_EN_BIT];
      next_s.prescale_select =
        ddtc_pre_t'(ctrl_new[DDTC_CTRL_PRE_HI:DDTC_CTRL_PRE_LO]);
      next_s.counter_width_select =
        ctrl_new[DDTC_CTRL_WIDTH_BIT];
    end

    // primary load: shared reload plus a pending direct load
    // the load lands even while stopped, so the count can be
    // preset before the timer is enabled
    if (wr_load) begin
      next_s.reload = ddtc_merge(s.reload, wb_dat_i, wb_sel_i);
      next_s.direct_load = ddtc_merge(s.reload, wb_dat_i, wb_sel_i);
      next_s.load_pending = 1'b1;
    end

    // background load touches only the reload value
    if (wr_bg) begin
      next_s.reload = ddtc_merge(s.reload, wb_dat_i, wb_sel_i);
    end

    // count update on qualified edges
    // a direct load is not prescaled and lands on any qualified edge
    if (load_lands) begin
      next_s.count = s.direct_load;
      if (!wr_load) begin
        next_s.load_pending = 1'b0;
      end
    end else if (count_tick) begin
      next_s.count = ddtc_count_step(s.count, s.counter_width_select,
        s.periodic_select, s.reload);
    end

    // sticky raw flag; clear by any write, a new event wins
    // so a zero reached in the clear cycle is never lost
    if (wr_clear) begin
      next_s.raw_irq = 1'b0;
    end
    if (hit_zero || (load_lands &&
        ddtc_active(s.direct_load, s.counter_width_select) ==
        DDTC_ZERO)) begin
      next_s.raw_irq = 1'b1;
    end

    // output flop follows the masked flag with no lag
    next_s.irq_line = next_s.raw_irq && next_s.irq_mask_enable;

    // edge detector history
    next_s.clk_prev = clk_level;
  end

  // ========================================================
  // state register
  // reset branch holds constants only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s.ack <= 1'b0;
      s.rdata <= DDTC_ZERO;
      s.reload <= DDTC_RST_RELOAD;
      s.direct_load <= DDTC_RST_RELOAD;
      s.load_pending <= 1'b0;
      s.count <= DDTC_RST_COUNT;
      s.timer_run_enable <= DDTC_RST_RUN;
      s.periodic_select <= DDTC_RST_PERIODIC;
      s.irq_mask_enable <= DDTC_RST_IRQ_EN;
      s.prescale_select <= DDTC_PRE_DIV1;
      s.counter_width_select <= DDTC_RST_WIDTH;
      s.raw_irq <= 1'b0;
      s.irq_line <= 1'b0;
      s.clk_prev <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================
  // outputs
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdata;
  // interrupt pin straight from a flop, no glitches
  assign timer_irq_out = s.irq_line;
endmodule
`default_nettype wire
